// File: logic/nvm_bus_host.sv
// host-side controller driving the memory pins for reads, writes and command sequences
// How it works
// - reads drive chip select and output gate low, write strobe high
// - writes drive chip select and strobe low with output gate high
// - host takes a hardware reset only between requests, so a program is never interrupted
// - hardware id: id line high voltage, select line picks maker or part
// - host leaves id mode by writing reset command, any address
module nvm_bus_host
   import nvm_host_pkg::*;
#(
   parameter int ACC_CYC = ACCESS_CYC,
   parameter int RST_CYC = RESET_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // user request side
   input wire logic req_valid,
   input wire req_type req,
   input wire logic hw_reset_req,
   output logic req_ready,
   output logic rd_valid,
   output logic [DATA_W-1:0] rd_data,
   output logic in_id_mode,
   output logic in_secured_mode,
   output logic program_pending,
   // memory pins
   output pins_type pins,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_n,
   input wire logic [DATA_W-1:0] data_in
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD = 3'b010,
      ST_NEXT = 3'b110,
      ST_RESET = 3'b111
   } state_type;
   state_type state, next_state;
   pins_type next_pins;
   req_type cur, next_cur;
   logic [2:0] step, next_step;
   logic [2:0] steps, next_steps;
   logic next_req_ready, next_rd_valid, next_oe_n;
   logic [DATA_W-1:0] next_rd_data, next_data_out;
   logic next_id, next_sec, next_pend;
   logic is_read, next_is_read;
   logic tload;
   logic [CNT_W-1:0] tcount;
   logic tdone;
   nvm_cycle_timer #(.W(CNT_W)) timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .load(tload),
      .count(tcount),
      .done(tdone)
   );
   // pin cycles per operation; secured exit ends with a fourth write of 00
   function automatic logic [2:0] op_steps(input op_type op);
      unique case (op)
         OP_ID_ENTER, OP_SEC_ENTER: op_steps = 3'h3;
         OP_PROGRAM, OP_SEC_EXIT: op_steps = 3'h4;
         default: op_steps = 3'h1;
      endcase
   endfunction : op_steps
   // address and data of step n of a command sequence
   function automatic req_type step_word(input req_type r, input logic [2:0] n);
      req_type w;
      w = r;
      unique case (n)
         3'h0: begin
            w.addr = UNLOCK_ADDR1;
            w.data = CMD_UNLOCK1;
         end
         3'h1: begin
            w.addr = UNLOCK_ADDR2;
            w.data = CMD_UNLOCK2;
         end
         3'h2: begin
            w.addr = UNLOCK_ADDR1;
            unique case (r.op)
               OP_ID_ENTER: w.data = CMD_ID;
               OP_SEC_ENTER: w.data = CMD_SEC_ENTER;
               OP_SEC_EXIT: w.data = CMD_ID;
               default: w.data = CMD_PROGRAM;
            endcase
         end
         default: w.data = (r.op == OP_SEC_EXIT) ? CMD_SEC_EXIT : r.data;
      endcase
      return w;
   endfunction : step_word
   always_comb begin
      req_type w;
      w = step_word(cur, step);
      next_state = state;
      next_pins = pins;
      next_cur = cur;
      next_step = step;
      next_steps = steps;
      next_req_ready = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_data = rd_data;
      next_data_out = data_out;
      next_oe_n = data_oe_n;
      next_id = in_id_mode;
      next_sec = in_secured_mode;
      next_pend = program_pending;
      next_is_read = is_read;
      tload = 1'b0;
      tcount = '0;
      unique case (state)
         ST_IDLE: begin
            // standby between requests: chip select high, data floated
            next_pins.chip_sel_n = 1'b1;
            next_pins.out_gate_n = 1'b1;
            next_pins.write_n = 1'b1;
            next_oe_n = 1'b1;
            next_req_ready = 1'b1;
            if (hw_reset_req) begin
               // hold reset low for the minimum width
               next_pins.reset_n = 1'b0;
               next_req_ready = 1'b0;
               tload = 1'b1;
               tcount = CNT_W'(RST_CYC);
               next_state = ST_RESET;
            end else if (req_valid && req_ready) begin
               next_req_ready = 1'b0;
               next_cur = req;
               next_step = (req.op == OP_READ || req.op == OP_WRITE || req.op == OP_HW_ID ||
                  req.op == OP_RESET_CMD) ? 3'h3 : 3'h0;
               next_steps = op_steps(req.op);
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            next_is_read = (cur.op == OP_READ || cur.op == OP_HW_ID) && step == 3'h3;
            next_pins.addr = (cur.op == OP_RESET_CMD) ? cur.addr : w.addr;
            next_data_out = (cur.op == OP_RESET_CMD) ? CMD_RESET : w.data;
            next_pins.high_voltage_id_level = (cur.op == OP_HW_ID);
            if (cur.op == OP_HW_ID) begin
               // id line raised, lines six and one low
               next_pins.addr[ID_LOW_BIT_A] = 1'b0;
               next_pins.addr[ID_LOW_BIT_B] = 1'b0;
            end
            next_pins.chip_sel_n = 1'b0;
            tload = 1'b1;
            if (next_is_read) begin
               // read: gate low, strobe high, host floats the bus
               next_pins.out_gate_n = 1'b0;
               next_oe_n = 1'b1;
               tcount = CNT_W'(ACC_CYC);
            end else begin
               // write: gate high before strobe falls
               next_pins.out_gate_n = 1'b1;
               next_pins.write_n = 1'b0;
               next_oe_n = 1'b0;
               // strobe well over the glitch filter width
               tcount = CNT_W'(WRITE_LOW_CYC);
            end
            next_state = ST_STROBE;
         end
         ST_STROBE: begin
            if (tdone) begin
               if (is_read) begin
                  next_rd_data = data_in;
                  next_rd_valid = 1'b1;
                  next_pins.out_gate_n = 1'b1;
               end else begin
                  // rising strobe latches data still driven
                  next_pins.write_n = 1'b1;
               end
               next_pins.chip_sel_n = 1'b1;
               tload = 1'b1;
               tcount = CNT_W'(RECOVER_CYC);
               next_state = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (tdone) begin
               next_oe_n = 1'b1;
               next_state = ST_NEXT;
            end
         end
         ST_NEXT: begin
            if (step + 3'h1 < steps && step != 3'h3) begin
               next_step = step + 3'h1;
               next_state = ST_SETUP;
            end else begin
               // track which mode the device is in
               unique case (cur.op)
                  OP_ID_ENTER: next_id = 1'b1;
                  OP_SEC_ENTER: next_sec = 1'b1;
                  OP_SEC_EXIT: next_sec = 1'b0;
                  OP_RESET_CMD: next_id = 1'b0;
                  OP_PROGRAM: next_pend = 1'b0;
                  default: next_id = in_id_mode;
               endcase
               next_pins.high_voltage_id_level = 1'b0;
               next_state = ST_IDLE;
            end
            if (cur.op == OP_PROGRAM && step == 3'h0) begin
               next_pend = 1'b1;
            end
         end
         ST_RESET: begin
            if (tdone) begin
               // device back in array read, usable at once
               next_pins.reset_n = 1'b1;
               next_id = 1'b0;
               next_sec = 1'b0;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         pins <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1, reset_n: 1'b1,
            high_voltage_id_level: 1'b0, addr: '0};
         cur <= '0;
         step <= '0;
         steps <= '0;
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= '0;
         data_out <= '0;
         data_oe_n <= 1'b1;
         in_id_mode <= 1'b0;
         in_secured_mode <= 1'b0;
         program_pending <= 1'b0;
         is_read <= 1'b0;
      end else begin
         state <= next_state;
         pins <= next_pins;
         cur <= next_cur;
         step <= next_step;
         steps <= next_steps;
         req_ready <= next_req_ready;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
         data_out <= next_data_out;
         data_oe_n <= next_oe_n;
         in_id_mode <= next_id;
         in_secured_mode <= next_sec;
         program_pending <= next_pend;
         is_read <= next_is_read;
      end
   end
   // host drives data only with the output gate high
   no_contention_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !data_oe_n |-> pins.out_gate_n) else $error("host drives data while gate low");
   // write strobe never low with gate low
   write_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !pins.write_n |-> pins.out_gate_n && !pins.chip_sel_n) else $error("bad write pins");
   read_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !pins.out_gate_n |-> pins.write_n && !pins.chip_sel_n) else $error("bad read pins");
   // reset low lasts at least two cycles from the cycle it falls
   reset_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(pins.reset_n) |-> !pins.reset_n [*2]) else $error("reset pulse too short");
   // write strobe lasts beyond the glitch width
   strobe_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $fell(pins.write_n) |-> !pins.write_n [*2]) else $error("write strobe too short");
   idle_standby_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      req_ready |-> pins.chip_sel_n && data_oe_n) else $error("not in standby");
   // high voltage only during reads with lines six and one low
   hw_id_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pins.high_voltage_id_level && !pins.chip_sel_n |-> pins.write_n &&
      !pins.addr[ID_LOW_BIT_A] && !pins.addr[ID_LOW_BIT_B]) else $error("bad hw id pins");
   // after reset release the host is ready within a few cycles
   reset_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(pins.reset_n) |-> ##[1:3] req_ready) else $error("slow after reset");
endmodule : nvm_bus_host

// File: logic/nvm_cycle_timer.sv
// down counter giving a one-cycle done pulse after a loaded number of cycles
module nvm_cycle_timer
   import nvm_host_pkg::*;
#(
   parameter int W = CNT_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] remain;
   logic [W-1:0] next_remain;
   logic next_done;

   always_comb begin
      next_remain = remain;
      next_done = 1'b0;
      if (load) begin
         next_remain = count;
      end else if (remain != '0) begin
         next_remain = remain - W'(1);
         next_done = (remain == W'(1));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         remain <= '0;
         done <= 1'b0;
      end else begin
         remain <= next_remain;
         done <= next_done;
      end
   end
endmodule : nvm_cycle_timer

// File: logic/nvm_host_pkg.sv
// package: pin bundles, commands, timing counts for the memory host controller
package nvm_host_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int CLK_MHZ = 250;
   // timing in ns as specified, converted to sys_clk cycles
   localparam int ACCESS_TIME_NS = 90;
   localparam int AUTO_STBY_EXTRA_NS = 30;
   localparam int MIN_RESET_PULSE_NS = 500;
   localparam int GLITCH_NS = 5;
   localparam int WRITE_LOW_NS = 35;
   localparam int RECOVER_NS = 20;
   localparam int ACCESS_CYC = (ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_CYC = (MIN_RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_LOW_CYC = (WRITE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
   localparam int AUTO_STBY_CYC = ((ACCESS_TIME_NS + AUTO_STBY_EXTRA_NS) * CLK_MHZ) / 1000;
   localparam int CNT_W = 8;
   // command words and unlock addresses
   localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
   localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   localparam logic [15:0] CMD_ID = 16'h0090;
   localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
   localparam logic [15:0] CMD_SEC_EXIT = 16'h0000;
   localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
   localparam logic [19:0] UNLOCK_ADDR1 = 20'h0_0555;
   localparam logic [19:0] UNLOCK_ADDR2 = 20'h0_02AA;
   // hardware id: raised id line, maker or part select line, lines forced low
   localparam int ID_ENABLE_BIT = 9;
   localparam int ID_SELECT_BIT = 0;
   localparam int ID_LOW_BIT_A = 1;
   localparam int ID_LOW_BIT_B = 6;
   localparam int LOCK_INDICATOR_BIT = 7;
   localparam logic [19:0] SECURED_LAST = 20'h0_01FF;

   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_WRITE = 3'h1,
      OP_ID_ENTER = 3'h2,
      OP_SEC_ENTER = 3'h3,
      OP_SEC_EXIT = 3'h4,
      OP_PROGRAM = 3'h5,
      OP_RESET_CMD = 3'h6,
      OP_HW_ID = 3'h7
   } op_type;

   typedef struct packed {
      logic chip_sel_n;
      logic out_gate_n;
      logic write_n;
      logic reset_n;
      logic high_voltage_id_level;
      logic [ADDR_W-1:0] addr;
   } pins_type;

   typedef struct packed {
      op_type op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } req_type;
endpackage : nvm_host_pkg

// File: sim/nvm_bus_host_tb.sv
// self-checking bench for the memory host controller against the device model
module nvm_bus_host_tb;
   import nvm_host_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
   localparam logic [15:0] PART = 16'h5A3C; // arbitrary value
   logic sys_clk, rst_n, req_valid, hw_reset_req, req_ready, rd_valid;
   logic in_id_mode, in_secured_mode, data_oe_n, saw_rst, program_pending;
   req_type req;
   pins_type pins;
   logic [DATA_W-1:0] rd_data, data_out, data_in;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   nvm_bus_host #(.ACC_CYC(4), .RST_CYC(3)) nvm_bus_host_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .req_valid(req_valid), .req(req), .hw_reset_req(hw_reset_req), .req_ready(req_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .in_id_mode(in_id_mode),
      .in_secured_mode(in_secured_mode), .program_pending(program_pending), .pins(pins),
      .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in));
   nvm_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) nvm_device_model_i (
      .sys_clk(sys_clk), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
      .data_in(data_in));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // hangs end here; whole run is under a thousand cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end
   // pin levels watched mid-cycle, away from the launching edge
   always @(negedge sys_clk) begin
      if (rst_n && !pins.out_gate_n) chk("read pins", {pins.chip_sel_n, pins.write_n, data_oe_n}, 3'b011);
      if (rst_n && !pins.write_n) chk("write pins", {pins.chip_sel_n, pins.out_gate_n}, 2'b01);
      if (!pins.reset_n) saw_rst = 1'b1;
   end
   task automatic wait_ready();
      @(negedge sys_clk);
      // a request that never completes ends in the cycle ceiling
      while (req_ready !== 1'b1) @(negedge sys_clk);
   endtask : wait_ready
   task automatic send(op_type op, logic [19:0] a, logic [15:0] d);
      wait_ready();
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= '{op: op, addr: a, data: d};
      @(posedge sys_clk);
      req_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : send
   task automatic rd(op_type op, logic [19:0] a, logic [15:0] exp);
      send(op, a, 16'h0000);
      while (rd_valid !== 1'b1) @(negedge sys_clk);
      chk("read data", rd_data, exp);
   endtask : rd
   function automatic logic [15:0] arr(logic [19:0] a);
      return 16'h3C00 ^ {8'h00, a[7:0]};
   endfunction : arr
   task automatic t_boot_and_program();
      rd(OP_READ, 20'h0_0012, arr(20'h0_0012));
      send(OP_PROGRAM, 20'h0_0040, 16'hBEEF);
      // mid sequence: first unlock done, data word not yet written
      repeat (30) @(negedge sys_clk);
      chk("pending", program_pending, 1'b1);
      wait_ready();
      chk("pending", program_pending, 1'b0);
      send(OP_PROGRAM, 20'h0_0041, 16'h0F0F);
      rd(OP_READ, 20'h0_0040, 16'hBEEF);
      rd(OP_READ, 20'h0_0041, 16'h0F0F);
   endtask : t_boot_and_program
   task automatic t_stray_writes();
      send(OP_WRITE, 20'h0_0050, 16'h1234);
      send(OP_WRITE, UNLOCK_ADDR1, CMD_UNLOCK1);
      send(OP_WRITE, 20'h0_0050, 16'h4321);
      rd(OP_READ, 20'h0_0050, arr(20'h0_0050));
   endtask : t_stray_writes
   task automatic t_id_mode();
      send(OP_ID_ENTER, 20'h0_0000, 16'h0000);
      wait_ready();
      chk("id flag", in_id_mode, 1'b1);
      rd(OP_READ, 20'h0_0000, MAKER);
      rd(OP_READ, 20'h0_0001, PART);
      rd(OP_READ, 20'h0_0003, 16'h0088);
      send(OP_RESET_CMD, 20'h0_0123, CMD_RESET);
      wait_ready();
      chk("id flag", in_id_mode, 1'b0);
      rd(OP_READ, 20'h0_0001, arr(20'h0_0001));
      rd(OP_HW_ID, 20'h0_0000, MAKER);
      rd(OP_HW_ID, 20'h0_0001, PART);
   endtask : t_id_mode
   task automatic t_secured();
      send(OP_SEC_ENTER, 20'h0_0000, 16'h0000);
      wait_ready();
      chk("secured flag", in_secured_mode, 1'b1);
      rd(OP_READ, SECURED_LAST, {7'h28, SECURED_LAST[8:0]});
      send(OP_PROGRAM, 20'h0_0005, 16'h1111);
      rd(OP_READ, 20'h0_0005, {7'h28, 9'h005});
      rd(OP_READ, 20'h0_0300, arr(20'h0_0300));
      send(OP_SEC_EXIT, 20'h0_0000, CMD_SEC_EXIT);
      wait_ready();
      chk("secured flag", in_secured_mode, 1'b0);
      rd(OP_READ, 20'h0_0005, arr(20'h0_0005));
   endtask : t_secured
   task automatic t_hw_reset();
      send(OP_SEC_ENTER, 20'h0_0000, 16'h0000);
      saw_rst = 1'b0;
      wait_ready();
      @(posedge sys_clk);
      hw_reset_req <= 1'b1;
      @(posedge sys_clk);
      hw_reset_req <= 1'b0;
      wait_ready();
      chk("reset pulse", saw_rst, 1'b1);
      chk("secured flag", in_secured_mode, 1'b0);
      rd(OP_READ, 20'h0_0005, arr(20'h0_0005));
   endtask : t_hw_reset
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      hw_reset_req = 1'b0;
      saw_rst = 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_boot_and_program();
      t_stray_writes();
      t_id_mode();
      t_secured();
      t_hw_reset();
      wrap_up();
   end
endmodule : nvm_bus_host_tb

// File: sim/nvm_device_model.sv
// behavioural model of the memory device behind the host controller pins
module nvm_device_model
   import nvm_host_pkg::*;
#(
   parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
   parameter logic [15:0] PART_CODE = 16'h5A3C, // arbitrary value
   parameter bit FACTORY_LOCKED = 1'b1
) (
   // clock
   input wire logic sys_clk,
   // device pins
   input wire pins_type pins,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe_n,
   output logic [DATA_W-1:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:255];
   logic [15:0] rword;
   logic [15:0] last = 16'h0000;
   logic [19:0] cmd_addr = 20'h0_0000;
   logic [2:0] step = 3'd0;
   logic id_mode = 1'b0;
   logic sec_mode = 1'b0;
   logic prev_we = 1'b1;
   logic reading;
   int low_cnt = 0;
   int busy = 0;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'h3C00 ^ 16'(i);
   always @* begin
      if (pins.high_voltage_id_level && !pins.addr[6] && !pins.addr[1])
         rword = pins.addr[0] ? PART_CODE : MAKER_CODE;
      else if (id_mode)
         rword = pins.addr[1:0] == 2'd0 ? MAKER_CODE :
                 pins.addr[1:0] == 2'd1 ? PART_CODE : {8'h00, FACTORY_LOCKED, 7'h08};
      else if (sec_mode && pins.addr <= SECURED_LAST)
         rword = {7'h28, pins.addr[8:0]};
      else
         rword = mem[pins.addr[7:0]];
   end
   // released bus shows no stale value; auto standby is invisible
   assign reading = !pins.chip_sel_n && !pins.out_gate_n && pins.write_n && pins.reset_n;
   assign data_in = reading ? rword : ~last;
   always @(posedge sys_clk) begin
      last <= data_in;
      prev_we <= pins.write_n;
      // reset pin returns to array read at once
      if (!pins.reset_n) begin
         step <= 3'd0;
         id_mode <= 1'b0;
         sec_mode <= 1'b0;
         busy <= 0;
         low_cnt <= 0;
      end else begin
         if (busy > 0) busy <= busy - 1;
         // address taken as the strobe falls
         if (!pins.write_n && !pins.chip_sel_n && pins.out_gate_n) begin
            low_cnt <= low_cnt + 1;
            if (low_cnt == 0) cmd_addr <= pins.addr;
         end else low_cnt <= 0;
         // data on rising strobe, short strobes and busy ignored
         if (pins.write_n && !prev_we && low_cnt >= 2 && busy == 0 && !data_oe_n) begin
            if (step == 3'd3) begin
               if (!sec_mode) mem[cmd_addr[7:0]] <= data_out;
               busy <= 3;
               step <= 3'd0;
            end else if (step == 3'd4) begin
               if (data_out == CMD_SEC_EXIT) sec_mode <= 1'b0;
               step <= 3'd0;
            end else if (data_out == CMD_RESET) begin
               step <= 3'd0;
               id_mode <= 1'b0;
            end else if (step == 3'd0 && cmd_addr == UNLOCK_ADDR1 && data_out == CMD_UNLOCK1)
               step <= 3'd1;
            else if (step == 3'd1 && cmd_addr == UNLOCK_ADDR2 && data_out == CMD_UNLOCK2)
               step <= 3'd2;
            else if (step == 3'd2 && cmd_addr == UNLOCK_ADDR1 && data_out == CMD_ID) begin
               if (sec_mode) step <= 3'd4;
               else id_mode <= 1'b1;
               if (!sec_mode) step <= 3'd0;
            end else if (step == 3'd2 && cmd_addr == UNLOCK_ADDR1 && data_out == CMD_SEC_ENTER) begin
               sec_mode <= 1'b1;
               step <= 3'd0;
            end else if (step == 3'd2 && cmd_addr == UNLOCK_ADDR1 && data_out == CMD_PROGRAM)
               step <= 3'd3;
            else step <= 3'd0;
         end
      end
   end
endmodule : nvm_device_model
